// [agu_defs.svh]
/*
 * Constants of the address generation unit: register offsets, field
 * positions, reset values and address widths.
 * Assumes inclusion by bare name from the package and the design.
 */
`ifndef AGU_DEFS_SVH
`define AGU_DEFS_SVH

// ****************************************
// register byte offsets on the bus
// ****************************************
`define AGU_OFS_BREV        12'h000
`define AGU_OFS_TBLPAGE     12'h004
`define AGU_OFS_VISPAGE     12'h008
`define AGU_OFS_MODCTL      12'h00c
`define AGU_OFS_MODSTART    12'h010
`define AGU_OFS_MODEND      12'h014
`define AGU_OFS_STATUS      12'h018

// ****************************************
// field positions and reset values
// ****************************************
`define AGU_BREV_EN_BIT     15
`define AGU_MOD_EN_BIT      15
`define AGU_PTR_NONE        4'hf
`define AGU_TBL_CFG_BIT     7
`define AGU_BREV_RST        16'h0000
`define AGU_TBLPAGE_RST     8'h00
`define AGU_VISPAGE_RST     8'h00
`define AGU_MODCTL_RST      16'h00ff
`define AGU_MODSTART_RST    16'h0000
`define AGU_MODEND_RST      16'h0001

// ****************************************
// address widths
// ****************************************
`define AGU_DATA_W          16
`define AGU_PROG_W          24

`endif

// [agu_pkg.sv]
/*
 * Types shared by the address generation unit.
 * Assumes agu_defs.svh is on the include path.
 */
`include "agu_defs.svh"

package agu_pkg;

  // addressing modes issued by the pipeline
  typedef enum logic [2:0] {
    AGU_AM_DIRECT   = 3'h0,
    AGU_AM_POSTINC  = 3'h1,
    AGU_AM_POSTDEC  = 3'h2,
    AGU_AM_PREINC   = 3'h3,
    AGU_AM_PREDEC   = 3'h4,
    AGU_AM_OFFSET   = 3'h5
  } agu_mode_t;

  // kind of program space access
  typedef enum logic [1:0] {
    AGU_PS_FETCH    = 2'h0,
    AGU_PS_TABLE    = 2'h1,
    AGU_PS_VISIBLE  = 2'h2,
    AGU_PS_NONE     = 2'h3
  } agu_ps_t;

  // bus slave state
  typedef enum logic [1:0] {
    AGU_BS_IDLE     = 2'h0,
    AGU_BS_RESP     = 2'h1
  } agu_bstate_t;

endpackage

// [agu_core.sv]
/*
 * Effective address generation unit of a 16-bit signal processor core:
 * modulo wrap and write-back, bit-reversed write addressing, and
 * program space address formation for table and visibility accesses.
 * Assumes one synchronous clock and an AXI4-Lite master for registers;
 * the pipeline presents one request per cycle and takes results
 * from flip-flops one cycle later.
 */
`timescale 1ns/10ps
`include "agu_defs.svh"

module agu_core (
  input  wire logic              clk_sys,
  input  wire logic              srst,
  // ****************************************
  // register bus
  // ****************************************
  input  wire logic [11:0]       s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [11:0]       s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // ****************************************
  // pipeline request
  // ****************************************
  input  wire logic              req_valid,
  input  wire logic [3:0]        req_wsel,
  input  wire logic [15:0]       req_wptr,
  input  wire logic [15:0]       req_step,
  input  wire agu_pkg::agu_mode_t req_mode,
  input  wire logic              req_byte,
  input  wire logic              req_write,
  input  wire agu_pkg::agu_ps_t  req_ps,
  input  wire logic [23:0]       req_pc,
  // ****************************************
  // results
  // ****************************************
  output logic                   ea_valid,
  output logic [15:0]            ea_addr,
  output logic                   wb_en,
  output logic [3:0]             wb_sel,
  output logic [15:0]            wb_data,
  output logic                   ps_valid,
  output logic [23:0]            ps_addr,
  output logic                   ps_cfg,
  output logic                   ps_low_word,
  output logic                   ps_refused
);
  import agu_pkg::*;

  // ****************************************
  // registers
  // ****************************************
  logic [15:0] brev_ctl_r;
  logic [7:0]  tbl_page_r;
  logic [7:0]  vis_page_r;
  logic [15:0] mod_ctl_r;
  logic [15:0] mod_start_r;
  logic [15:0] mod_end_r;
  logic        wrap_seen_r;
  logic        brev_seen_r;
  agu_bstate_t wst_r;
  agu_bstate_t rst_r;
  logic        aw_got_r;
  logic        w_got_r;
  logic [11:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;

  function automatic logic [15:0] bitrev16(input logic [15:0] v);
    logic [15:0] o;
    o = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      o[i] = v[15-i];
    end
    return o;
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0]  s);
    logic [15:0] o;
    o = old;
    if (s[0]) begin
      o[7:0] = d[7:0];
    end
    if (s[1]) begin
      o[15:8] = d[15:8];
    end
    return o;
  endfunction

  // ****************************************
  // write channel: address and data in any order
  // ****************************************
  assign s_axi_awready = (wst_r == AGU_BS_IDLE) && !aw_got_r;
  assign s_axi_wready  = (wst_r == AGU_BS_IDLE) && !w_got_r;
  assign s_axi_bresp   = 2'h0;
  assign s_axi_bvalid  = (wst_r == AGU_BS_RESP);

  logic aw_fire;
  logic w_fire;
  logic do_write;
  logic [11:0] wa;
  logic [31:0] wd;
  logic [3:0]  ws;
  assign aw_fire  = s_axi_awvalid && s_axi_awready;
  assign w_fire   = s_axi_wvalid && s_axi_wready;
  assign do_write = (aw_got_r || aw_fire) && (w_got_r || w_fire) &&
                    (wst_r == AGU_BS_IDLE);
  assign wa = aw_got_r ? aw_addr_r : s_axi_awaddr;
  assign wd = w_got_r ? w_data_r : s_axi_wdata;
  assign ws = w_got_r ? w_strb_r : s_axi_wstrb;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wst_r     <= AGU_BS_IDLE;
      aw_got_r  <= 1'b0;
      w_got_r   <= 1'b0;
      aw_addr_r <= 12'h000;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
    end else begin
      case (wst_r)
        AGU_BS_IDLE: begin
          if (aw_fire) begin
            aw_addr_r <= s_axi_awaddr;
          end
          if (w_fire) begin
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
          end
          if (do_write) begin
            wst_r    <= AGU_BS_RESP;
            aw_got_r <= 1'b0;
            w_got_r  <= 1'b0;
          end else begin
            aw_got_r <= aw_got_r || aw_fire;
            w_got_r  <= w_got_r || w_fire;
          end
        end
        AGU_BS_RESP: begin
          if (s_axi_bready) begin
            wst_r <= AGU_BS_IDLE;
          end
        end
        default: wst_r <= AGU_BS_IDLE;
      endcase
    end
  end

  // unmapped writes are accepted and dropped
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      brev_ctl_r  <= `AGU_BREV_RST;
      tbl_page_r  <= `AGU_TBLPAGE_RST;
      vis_page_r  <= `AGU_VISPAGE_RST;
      mod_ctl_r   <= `AGU_MODCTL_RST;
      mod_start_r <= `AGU_MODSTART_RST;
      mod_end_r   <= `AGU_MODEND_RST;
    end else if (do_write) begin
      case (wa)
        `AGU_OFS_BREV:     brev_ctl_r  <= merge16(brev_ctl_r, wd, ws);
        `AGU_OFS_TBLPAGE: begin
          if (ws[0]) begin
            tbl_page_r <= wd[7:0];
          end
        end
        `AGU_OFS_VISPAGE: begin
          if (ws[0]) begin
            vis_page_r <= wd[7:0];
          end
        end
        `AGU_OFS_MODCTL:   mod_ctl_r   <= merge16(mod_ctl_r, wd, ws);
        `AGU_OFS_MODSTART: mod_start_r <= merge16(mod_start_r, wd, ws);
        `AGU_OFS_MODEND:   mod_end_r   <= merge16(mod_end_r, wd, ws);
        default: ;
      endcase
    end
  end

  // ****************************************
  // read channel
  // ****************************************
  assign s_axi_arready = (rst_r == AGU_BS_IDLE);
  assign s_axi_rresp   = 2'h0;
  assign s_axi_rvalid  = (rst_r == AGU_BS_RESP);

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rst_r       <= AGU_BS_IDLE;
      s_axi_rdata <= 32'h0000_0000;
    end else begin
      case (rst_r)
        AGU_BS_IDLE: begin
          if (s_axi_arvalid) begin
            rst_r <= AGU_BS_RESP;
            case (s_axi_araddr)
              `AGU_OFS_BREV:     s_axi_rdata <= {16'h0000, brev_ctl_r};
              `AGU_OFS_TBLPAGE:  s_axi_rdata <= {24'h000000, tbl_page_r};
              `AGU_OFS_VISPAGE:  s_axi_rdata <= {24'h000000, vis_page_r};
              `AGU_OFS_MODCTL:   s_axi_rdata <= {16'h0000, mod_ctl_r};
              `AGU_OFS_MODSTART: s_axi_rdata <= {16'h0000, mod_start_r};
              `AGU_OFS_MODEND:   s_axi_rdata <= {16'h0000, mod_end_r};
              `AGU_OFS_STATUS:   s_axi_rdata <= {30'h0000_0000,
                                                 brev_seen_r, wrap_seen_r};
              default:           s_axi_rdata <= 32'h0000_0000;
            endcase
          end
        end
        AGU_BS_RESP: begin
          if (s_axi_rready) begin
            rst_r <= AGU_BS_IDLE;
          end
        end
        default: rst_r <= AGU_BS_IDLE;
      endcase
    end
  end

  // ****************************************
  // data effective address
  // ****************************************
  logic        mod_en;
  logic        is_inc;
  logic        is_dec;
  logic        is_pre;
  logic        modifies;
  logic        brev_act;
  logic [15:0] sum;
  logic [15:0] stepped;
  logic [15:0] ea_raw;
  logic [15:0] ea_fix;
  logic [15:0] new_ptr;
  logic [15:0] pivot;
  logic        wrap_hit;

  assign is_inc   = (req_mode == AGU_AM_POSTINC) ||
                    (req_mode == AGU_AM_PREINC);
  assign is_dec   = (req_mode == AGU_AM_POSTDEC) ||
                    (req_mode == AGU_AM_PREDEC);
  assign is_pre   = (req_mode == AGU_AM_PREINC) ||
                    (req_mode == AGU_AM_PREDEC);
  assign modifies = is_inc || is_dec;

  assign brev_act = brev_ctl_r[`AGU_BREV_EN_BIT] &&
                    (mod_ctl_r[7:4] != `AGU_PTR_NONE) &&
                    (req_wsel == mod_ctl_r[7:4]) &&
                    is_inc && req_write && !req_byte;

  // fifteen bit pivot scaled to bytes
  assign pivot = {brev_ctl_r[14:0], 1'b0};

  assign sum = bitrev16(bitrev16(req_wptr) + bitrev16(pivot)) &
               16'hfffe;

  assign mod_en = mod_ctl_r[`AGU_MOD_EN_BIT] &&
                  (mod_ctl_r[3:0] != `AGU_PTR_NONE) &&
                  (req_wsel == mod_ctl_r[3:0]);

  assign stepped = is_dec ? (req_wptr - req_step) : (req_wptr + req_step);

  // strictly beyond bound only, equal does not wrap
  always_comb begin
    wrap_hit = 1'b0;
    if (is_inc || req_mode == AGU_AM_OFFSET) begin
      wrap_hit = stepped > mod_end_r;
    end else if (is_dec) begin
      wrap_hit = stepped < mod_start_r;
    end
  end

  // reversal disables modulo for writes; reads keep it
  always_comb begin
    ea_fix = stepped;
    if (brev_act) begin
      ea_fix = sum;
    end else if (mod_en && wrap_hit) begin
      ea_fix = is_dec ? (stepped + (mod_end_r - mod_start_r) +
                         16'h0001)
                      : (stepped - (mod_end_r - mod_start_r) -
                         16'h0001);
    end
  end

  assign new_ptr = ea_fix;
  // offset mode uses the corrected address only
  assign ea_raw  = (req_mode == AGU_AM_OFFSET) ? ea_fix :
                   (is_pre ? ea_fix : (brev_act ? req_wptr & 16'hfffe
                                                : req_wptr));

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ea_valid <= 1'b0;
      ea_addr  <= 16'h0000;
    end else begin
      ea_valid <= req_valid;
      ea_addr  <= ea_raw;
    end
  end

  // write back only in modify modes
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wb_en   <= 1'b0;
      wb_sel  <= 4'h0;
      wb_data <= 16'h0000;
    end else begin
      wb_en   <= req_valid && modifies;
      wb_sel  <= req_wsel;
      wb_data <= new_ptr;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wrap_seen_r <= 1'b0;
      brev_seen_r <= 1'b0;
    end else if (req_valid) begin
      wrap_seen_r <= mod_en && wrap_hit && !brev_act;
      brev_seen_r <= brev_act;
    end
  end

  // ****************************************
  // program space address
  // ****************************************
  // 24-bit program, 16-bit data
  logic [23:0] ps_nxt;
  logic        cfg_nxt;
  always_comb begin
    ps_nxt  = 24'h000000;
    cfg_nxt = 1'b0;
    case (req_ps)
      AGU_PS_FETCH:   ps_nxt = {1'b0, req_pc[22:1], 1'b0};
      AGU_PS_TABLE: begin
        ps_nxt  = {tbl_page_r, req_wptr};
        cfg_nxt = tbl_page_r[`AGU_TBL_CFG_BIT];
      end
      // page bit 0 lands at bit 15
      AGU_PS_VISIBLE: ps_nxt = {1'b0, vis_page_r, req_wptr[14:0]};
      AGU_PS_NONE:    ps_nxt = 24'h000000;
      default:        ps_nxt = 24'h000000;
    endcase
  end

  logic vis_ok;
  // only ea bit 15 set reads remap
  assign vis_ok = (req_ps == AGU_PS_VISIBLE) && req_wptr[15] &&
                  !req_write;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ps_valid    <= 1'b0;
      ps_addr     <= 24'h000000;
      ps_cfg      <= 1'b0;
      ps_low_word <= 1'b0;
      ps_refused  <= 1'b0;
    end else begin
      ps_valid    <= req_valid && (req_ps != AGU_PS_NONE) &&
                     (req_ps != AGU_PS_VISIBLE || vis_ok);
      ps_addr     <= ps_nxt;
      ps_cfg      <= cfg_nxt;
      ps_low_word <= req_valid && vis_ok;
      ps_refused  <= req_valid && (req_ps == AGU_PS_VISIBLE) && !vis_ok;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  property p_wb_mode;
    @(posedge clk_sys) disable iff (srst)
      req_valid && (req_mode == AGU_AM_OFFSET) |=> !wb_en;
  endproperty
  a_wb_mode: assert property (p_wb_mode)
    else $error("write back in offset mode");

  property p_brev_align;
    @(posedge clk_sys) disable iff (srst)
      req_valid && brev_act && is_pre |=> ea_addr[0] == 1'b0;
  endproperty
  a_brev_align: assert property (p_brev_align)
    else $error("reversed address not word aligned");

  property p_brev_byte;
    @(posedge clk_sys) disable iff (srst)
      req_byte |-> !brev_act;
  endproperty
  a_brev_byte: assert property (p_brev_byte)
    else $error("reversal on byte access");

  property p_brev_read;
    @(posedge clk_sys) disable iff (srst)
      !req_write |-> !brev_act;
  endproperty
  a_brev_read: assert property (p_brev_read)
    else $error("reversal on read");

  property p_tbl;
    @(posedge clk_sys) disable iff (srst)
      req_valid && req_ps == AGU_PS_TABLE |=>
        ps_addr == {$past(tbl_page_r), $past(req_wptr)} &&
        ps_cfg == ps_addr[23];
  endproperty
  a_tbl: assert property (p_tbl)
    else $error("table address wrong");

  property p_vis;
    @(posedge clk_sys) disable iff (srst)
      req_valid && vis_ok |=> ps_addr[23] == 1'b0 &&
        ps_addr[15] == $past(vis_page_r[0]) && ps_low_word;
  endproperty
  a_vis: assert property (p_vis)
    else $error("visibility address wrong");

  property p_vis_wr;
    @(posedge clk_sys) disable iff (srst)
      req_valid && req_ps == AGU_PS_VISIBLE && req_write |=>
        ps_refused && !ps_valid;
  endproperty
  a_vis_wr: assert property (p_vis_wr)
    else $error("visibility write not refused");

  property p_fetch;
    @(posedge clk_sys) disable iff (srst)
      req_valid && req_ps == AGU_PS_FETCH |=>
        ps_addr[23] == 1'b0 && ps_addr[0] == 1'b0;
  endproperty
  a_fetch: assert property (p_fetch)
    else $error("fetch address bits wrong");

  property p_wrap;
    @(posedge clk_sys) disable iff (srst)
      req_valid && mod_en && !brev_act && is_inc && stepped > mod_end_r
        |=> wrap_seen_r;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("missed wrap");

  c_wrap: cover property (@(posedge clk_sys) disable iff (srst)
    req_valid && mod_en && wrap_hit);
  c_brev: cover property (@(posedge clk_sys) disable iff (srst)
    req_valid && brev_act);
  c_vis:  cover property (@(posedge clk_sys) disable iff (srst)
    req_valid && vis_ok);
  c_cfg:  cover property (@(posedge clk_sys) disable iff (srst)
    req_valid && req_ps == AGU_PS_TABLE && tbl_page_r[7]);

endmodule

// [agu_pipe_model.sv]
/*
 * Pipeline side model: issues one address request at a time.
 * Assumes the bench calls issue() and reads results at the negedge.
 */
`timescale 1ns/10ps

module agu_pipe_model (
  input  wire logic         clk_sys,
  output logic              req_valid,
  output logic [3:0]        req_wsel,
  output logic [15:0]       req_wptr,
  output logic [15:0]       req_step,
  output agu_pkg::agu_mode_t req_mode,
  output logic              req_byte,
  output logic              req_write,
  output agu_pkg::agu_ps_t  req_ps,
  output logic [23:0]       req_pc
);
  import agu_pkg::*;

  initial begin
    req_valid = 1'b0;
    req_wsel  = 4'h0;
    req_wptr  = 16'h0000;
    req_step  = 16'h0000;
    req_mode  = AGU_AM_DIRECT;
    req_byte  = 1'b0;
    req_write = 1'b0;
    req_ps    = AGU_PS_NONE;
    req_pc    = 24'h000000;
  end

  // callers keep buffers aligned, no read after control write
  task automatic issue(input logic [3:0] sel, input logic [15:0] ptr,
                       input logic [15:0] step, input agu_mode_t m,
                       input logic byt, input logic wr, input agu_ps_t ps,
                       input logic [23:0] pc);
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req_wsel  <= sel;
    req_wptr  <= ptr;
    req_step  <= step;
    req_mode  <= m;
    req_byte  <= byt;
    req_write <= wr;
    req_ps    <= ps;
    req_pc    <= pc;
    @(posedge clk_sys);
    // idle pointer, step and pc show garbage so stale values are never trusted
    req_valid <= 1'b0;
    req_wptr  <= ~ptr;
    req_step  <= ~step;
    req_pc    <= ~pc;
    @(negedge clk_sys);
  endtask
endmodule

// [tb.sv]
/*
 * Self-checking bench of the address generation unit.
 * Assumes agu_pkg, agu_defs.svh and agu_pipe_model are compiled first.
 */
`timescale 1ns/10ps
`include "agu_defs.svh"

module tb;
  import agu_pkg::*;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic [11:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic rv, wb_en, ps_valid, ps_cfg, ps_low, ps_ref, ea_valid, byt_q;
  logic rw;
  logic [3:0] wsel, wb_sel;
  logic [15:0] wptr, step, ea_addr, wb_data;
  logic [23:0] pc, ps_addr;
  agu_mode_t mode;
  agu_ps_t ps;
  int fail_count = 0, checks = 0, cyc = 0;

  always #12.5 clk_sys = ~clk_sys;

  agu_pipe_model i_agu_pipe_model (.clk_sys(clk_sys), .req_valid(rv),
    .req_wsel(wsel), .req_wptr(wptr), .req_step(step), .req_mode(mode),
    .req_byte(byt_q), .req_write(rw), .req_ps(ps), .req_pc(pc));

  agu_core i_agu_core (.clk_sys(clk_sys), .srst(srst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .req_valid(rv),
    .req_wsel(wsel), .req_wptr(wptr), .req_step(step), .req_mode(mode),
    .req_byte(byt_q), .req_write(rw), .req_ps(ps), .req_pc(pc),
    .ea_valid(ea_valid), .ea_addr(ea_addr), .wb_en(wb_en), .wb_sel(wb_sel),
    .wb_data(wb_data), .ps_valid(ps_valid), .ps_addr(ps_addr),
    .ps_cfg(ps_cfg), .ps_low_word(ps_low), .ps_refused(ps_ref));

  task automatic end_sim;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count = fail_count + 1;
      end_sim();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    checks = checks + 1;
    if (got !== exp) begin
      fail_count = fail_count + 1;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // handshakes judged at the negedge, released after the next posedge
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
    logic aw_hs, w_hs, aw_pend, w_pend;
    aw_pend = 1'b1;
    w_pend = 1'b1;
    @(posedge clk_sys);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
    bready <= 1'b1;
    // loop on own flags: valid still reads high until the nba lands
    while (aw_pend || w_pend) begin
      @(negedge clk_sys);
      aw_hs = aw_pend & awready;
      w_hs = w_pend & wready;
      @(posedge clk_sys);
      if (aw_hs) begin
        awvalid <= 1'b0;
        aw_pend = 1'b0;
      end
      if (w_hs) begin
        wvalid <= 1'b0;
        w_pend = 1'b0;
      end
    end
    do begin
      @(negedge clk_sys);
      aw_hs = bvalid;
      @(posedge clk_sys);
    end while (!aw_hs);
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d);
    logic hs;
    @(posedge clk_sys);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(negedge clk_sys);
      hs = arready;
      @(posedge clk_sys);
    end while (!hs);
    arvalid <= 1'b0;
    do begin
      @(negedge clk_sys);
      hs = rvalid;
      d = rdata;
      @(posedge clk_sys);
    end while (!hs);
    rready <= 1'b0;
  endtask

  // own reverse-carry add: reverse both, add, reverse back
  function automatic logic [15:0] rc_add(input logic [15:0] a,
                                         input logic [15:0] b);
    logic [15:0] ra, rb, s, r;
    for (int i = 0; i < 16; i++) begin
      ra[i] = a[15-i];
      rb[i] = b[15-i];
    end
    s = ra + rb;
    for (int i = 0; i < 16; i++) r[i] = s[15-i];
    return r;
  endfunction

  task automatic ea_case(input logic [3:0] s, input logic [15:0] p,
                         input logic [15:0] st, input agu_mode_t m,
                         input logic b, input logic w, input logic [15:0] ea,
                         input logic we, input logic [15:0] wb);
    i_agu_pipe_model.issue(s, p, st, m, b, w, AGU_PS_NONE, 24'h000000);
    chk(ea_valid, 1'b1, "ea_valid");
    chk(ea_addr, ea, "ea_addr");
    chk(wb_en, we, "wb_en");
    if (we) chk({wb_sel, wb_data}, {s, wb}, "write back");
  endtask

  task automatic t_reset_regs;
    logic [31:0] d;
    axi_rd(`AGU_OFS_BREV, d);     chk(d, 32'h0000, "brev reset");
    axi_rd(`AGU_OFS_TBLPAGE, d);  chk(d, 32'h00, "tbl reset");
    axi_rd(`AGU_OFS_VISPAGE, d);  chk(d, 32'h00, "vis reset");
    axi_rd(`AGU_OFS_MODCTL, d);   chk(d, 32'h00ff, "modctl reset");
    axi_rd(`AGU_OFS_MODEND, d);   chk(d, 32'h0001, "modend reset");
    axi_rd(12'h01c, d);           chk(d, 32'h0, "unmapped read");
  endtask

  task automatic t_modulo;
    logic [31:0] d;
    axi_wr(`AGU_OFS_MODSTART, 32'h1000);
    axi_wr(`AGU_OFS_MODEND, 32'h100f);
    axi_wr(`AGU_OFS_MODCTL, 32'h80f2);
    ea_case(4'h2, 16'h100e, 16'h2, AGU_AM_POSTINC, 0, 0, 16'h100e, 1, 16'h1000);
    axi_rd(`AGU_OFS_STATUS, d); chk(d, 32'h1, "wrap status");
    ea_case(4'h2, 16'h100c, 16'h6, AGU_AM_POSTINC, 0, 0, 16'h100c, 1, 16'h1002);
    ea_case(4'h2, 16'h1000, 16'h2, AGU_AM_POSTDEC, 0, 0, 16'h1000, 1, 16'h100e);
    ea_case(4'h2, 16'h100e, 16'h2, AGU_AM_PREINC, 0, 0, 16'h1000, 1, 16'h1000);
    ea_case(4'h2, 16'h100c, 16'h8, AGU_AM_OFFSET, 0, 0, 16'h1004, 0, 16'h0);
    ea_case(4'h4, 16'h100e, 16'h2, AGU_AM_POSTINC, 0, 0, 16'h100e, 1, 16'h1010);
    axi_wr(`AGU_OFS_MODCTL, 32'h80f9);
    ea_case(4'h9, 16'h100e, 16'h4, AGU_AM_PREINC, 0, 0, 16'h1002, 1, 16'h1002);
  endtask

  task automatic t_reverse;
    logic [15:0] p;
    logic [31:0] d;
    p = 16'h2000;
    axi_wr(`AGU_OFS_MODCTL, 32'h003f);
    axi_wr(`AGU_OFS_BREV, 32'h8004);
    for (int i = 0; i < 8; i++) begin
      ea_case(4'h3, p, 16'h2, AGU_AM_POSTINC, 0, 1, p, 1,
              rc_add(p, 16'h8) & 16'hfffe);
      p = rc_add(p, 16'h8) & 16'hfffe;
    end
    axi_rd(`AGU_OFS_STATUS, d); chk(d, 32'h2, "reversal status");
    ea_case(4'h3, 16'h2000, 16'h2, AGU_AM_PREINC, 0, 1, 16'h2008, 1, 16'h2008);
    ea_case(4'h3, 16'h2000, 16'h2, AGU_AM_POSTINC, 1, 1, 16'h2000, 1, 16'h2002);
    ea_case(4'h3, 16'h2000, 16'h2, AGU_AM_PREDEC, 0, 1, 16'h1ffe, 1, 16'h1ffe);
    ea_case(4'h3, 16'h2000, 16'h2, AGU_AM_POSTINC, 0, 0, 16'h2000, 1, 16'h2002);
    axi_wr(`AGU_OFS_MODCTL, 32'h00ff);
    ea_case(4'h3, 16'h2000, 16'h2, AGU_AM_POSTINC, 0, 1, 16'h2000, 1, 16'h2002);
    axi_wr(`AGU_OFS_MODCTL, 32'h8033);
    ea_case(4'h3, 16'h100e, 16'h2, AGU_AM_POSTINC, 0, 1, 16'h100e, 1,
            rc_add(16'h100e, 16'h8) & 16'hfffe);
    ea_case(4'h3, 16'h100e, 16'h2, AGU_AM_POSTINC, 0, 0, 16'h100e, 1, 16'h1000);
    axi_wr(`AGU_OFS_BREV, 32'h0000);
  endtask

  task automatic ps_case(input agu_ps_t k, input logic w, input logic [15:0] p,
                         input logic [23:0] c, input logic [27:0] exp);
    i_agu_pipe_model.issue(4'h1, p, 16'h0, AGU_AM_DIRECT, 0, w, k, c);
    chk({ps_valid, ps_cfg, ps_low, ps_ref, ps_addr}, exp, "program addr");
  endtask

  task automatic t_program;
    axi_wr(`AGU_OFS_MODCTL, 32'h00ff);
    axi_wr(`AGU_OFS_TBLPAGE, 32'h85);
    axi_wr(`AGU_OFS_VISPAGE, 32'h37);
    ps_case(AGU_PS_TABLE, 0, 16'h1235, 24'h0, {4'b1100, 24'h851235});
    ps_case(AGU_PS_TABLE, 1, 16'hfffe, 24'h0, {4'b1100, 24'h85fffe});
    axi_wr(`AGU_OFS_TBLPAGE, 32'h05);
    ps_case(AGU_PS_TABLE, 0, 16'h8001, 24'h0, {4'b1000, 24'h058001});
    ps_case(AGU_PS_VISIBLE, 0, 16'h9234, 24'h0, {4'b1010, 24'h1b9234});
    axi_wr(`AGU_OFS_VISPAGE, 32'hfe);
    ps_case(AGU_PS_VISIBLE, 0, 16'hc001, 24'h0, {4'b1010, 24'h7f4001});
    ps_case(AGU_PS_VISIBLE, 1, 16'hc001, 24'h0, {4'b0001, 24'h7f4001});
    ps_case(AGU_PS_VISIBLE, 0, 16'h4001, 24'h0, {4'b0001, 24'h7f4001});
    ps_case(AGU_PS_FETCH, 0, 16'h0, 24'hffffff, {4'b1000, 24'h7ffffe});
  endtask

  initial begin
    repeat (4) @(posedge clk_sys);
    srst <= 1'b0;
    t_reset_regs();
    t_modulo();
    t_reverse();
    t_program();
    end_sim();
  end
endmodule
